// File: src/adc_cycle_map.vh
// adc_cycle_map.vh : constants for the converter cycle and serial port
// assumes a 100 MHz system clock (mclk)
`ifndef ADC_CYCLE_MAP_VH
`define ADC_CYCLE_MAP_VH

`define CLK_PERIOD_NS      10
`define POR_TIME_NS        1000000
`define POR_CYCLES         ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define XFER_BITS          32
`define IN_WORD_BITS       8
`define ADDR_BITS          5
`define RESULT_BITS        32
`define DEFAULT_ADDR       5'h00
`define CTRL_UPDATE        3'h5
`define CTRL_KEEP_A        3'h4
`define CTRL_KEEP_B        3'h0
`define ISCK_HALF_CYCLES   16'h0032
`define CONV_CYCLES        32'h00001000
`define CONV_DIV_50HZ      32'h00001400
`define CONV_DIV_60HZ      32'h000010ab
`define FNULL_DIV          2560
`define OVER_CODE          32'h30000000
`define UNDER_CODE         32'h0fffffff
`define FIFO_DEPTH         8
`define FIFO_WIDTH         32

`endif

// File: src/result_fifo.v
// result_fifo.v : small flip-flop FIFO for finished conversion words
// assumes one clock, synchronous active-high reset
module result_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             mclk,
    input  wire             rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @* begin
        out_data = mem[rd_ptr];
    end

    always @(posedge mclk) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end

    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// File: src/adc_cycle_serial_port.v
// adc_cycle_serial_port.v : conversion / sleep / data-output cycle and serial port
// assumes all pins are synchronous to mclk; the analog core delivers a result
// word with over/underrange flags; rst stands for the external power-on event
//
// Functional notes
// - cycle is conversion, sleep, data output
// - after conversion sleep while select high
// - sleep holds result in shift register
// - select low enables output, wakes device
// - select high floats serial data output
// - conversion and sleep drive status out
// - select high before first clock: sleep
// - after first rising clock shift both ways
// - select rise mid transfer starts conversion
// - output bit changes on falling clock
// - output ends after 32 bits, converts
// - sample input on rising clock edges
// - new channel used by next conversion
// - serial input ignored outside data output
// - clock mode from pin at reset/select fall
// - pull-up enabled in internal clock mode
// - frequency pin level picks 50/60 null
// - clocked frequency pin is system clock
// - one output word per conversion
// - calibration inside conversion, timing unchanged
// - distinct overrange and underrange codes
// - modes set by pin timing only
// - 8-bit input word, control 101 updates
// - first address bit selects single-ended
// - first conversion uses address 00000
// - 1 ms internal reset clears registers
`include "adc_cycle_map.vh"
module adc_cycle_serial_port #(
    parameter POR_CYCLES = `POR_CYCLES,
    parameter CONV_CYCLES = `CONV_CYCLES,
    parameter ISCK_HALF  = `ISCK_HALF_CYCLES
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        cs_n,
    input  wire        sck_in,
    output reg         sck_out,
    output wire        sck_oe,
    output wire        sck_pullup,
    input  wire        sdi,
    output wire        sdo_out,
    output wire        sdo_oe,
    input  wire        freq_select_pin,
    input  wire        ext_clk_detect,
    input  wire [31:0] core_result,
    input  wire        core_overrange,
    input  wire        core_underrange,
    output reg         conv_start,
    input  wire        core_done,
    output reg  [4:0]  channel_addr,
    output wire        single_ended_select,
    output reg         calibrate,
    output reg  [1:0]  notch_mode,
    output wire [31:0] fifo_data,
    output wire        fifo_valid,
    input  wire        fifo_ready,
    output reg         busy
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam ST_POR   = 3'h0;
    localparam ST_CONV  = 3'h1;
    localparam ST_SLEEP = 3'h2;
    localparam ST_WAIT  = 3'h3;
    localparam ST_XFER  = 3'h4;

    reg [2:0]  state;
    reg [31:0] por_cnt;
    reg [31:0] conv_cnt;
    reg [31:0] shift_out;
    reg [7:0]  shift_in;
    reg [5:0]  bit_cnt;
    reg        int_mode;
    reg        cs_q;
    reg        sck_q;
    reg [15:0] div_cnt;
    reg        sdo_bit;
    reg [31:0] conv_word;
    reg        conv_pending;
    wire       sck_eff;
    wire       sck_rise;
    wire       sck_fall;
    wire       cs_fall;
    wire       cs_rise;
    wire       fifo_in_ready;
    reg        fifo_push;

    assign sck_eff  = int_mode ? sck_out : sck_in;
    assign sck_rise = sck_eff & ~sck_q;
    assign sck_fall = ~sck_eff & sck_q;
    assign cs_fall  = ~cs_n & cs_q;
    assign cs_rise  = cs_n & ~cs_q;

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    assign sdo_oe     = ~cs_n;
    // status: low when a result is ready (sleep), high while converting
    assign sdo_out    = (state == ST_XFER) ? sdo_bit :
                        (state == ST_WAIT) ? sdo_bit : (state != ST_SLEEP);
    assign sck_oe     = int_mode & (state == ST_XFER);
    assign sck_pullup = int_mode;
    assign single_ended_select = channel_addr[4];

    // ------------------------------------------------------------
    // conversion word with range codes
    // ------------------------------------------------------------
    always @* begin
        if (core_overrange) begin
            conv_word = `OVER_CODE;
        end else if (core_underrange) begin
            conv_word = `UNDER_CODE;
        end else begin
            conv_word = core_result;
        end
    end

    // ------------------------------------------------------------
    // main cycle
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            state        <= ST_POR;
            por_cnt      <= 32'h0;
            conv_cnt     <= 32'h0;
            shift_out    <= 32'h0;
            shift_in     <= 8'h0;
            bit_cnt      <= 6'h0;
            int_mode     <= 1'b0;
            cs_q         <= 1'b1;
            sck_q        <= 1'b0;
            sck_out      <= 1'b0;
            div_cnt      <= 16'h0;
            sdo_bit      <= 1'b1;
            conv_start   <= 1'b0;
            channel_addr <= `DEFAULT_ADDR;
            calibrate    <= 1'b0;
            notch_mode   <= 2'h0;
            busy         <= 1'b1;
            fifo_push    <= 1'b0;
            conv_pending <= 1'b0;
        end else begin
            cs_q       <= cs_n;
            sck_q      <= sck_eff;
            conv_start <= 1'b0;
            fifo_push  <= 1'b0;
            // notch: 2 = external clock, 1 = 50 Hz, 0 = 60 Hz
            notch_mode <= ext_clk_detect ? 2'h2 :
                          (freq_select_pin ? 2'h1 : 2'h0);
            case (state)
            ST_POR: begin
                por_cnt <= por_cnt + 32'h1;
                if (por_cnt >= POR_CYCLES - 1) begin
                    int_mode   <= ~sck_in;
                    state      <= ST_CONV;
                    conv_start <= 1'b1;
                    calibrate  <= 1'b1;
                    conv_cnt   <= 32'h0;
                end
            end
            ST_CONV: begin
                busy     <= 1'b1;
                conv_cnt <= conv_cnt + 32'h1;
                // calibration runs inside the fixed conversion time
                if (conv_cnt == (CONV_CYCLES >> 1)) begin
                    calibrate <= 1'b0;
                end
                if (core_done || conv_cnt >= CONV_CYCLES - 1) begin
                    shift_out <= conv_word;
                    sdo_bit   <= conv_word[`RESULT_BITS-1];
                    fifo_push <= 1'b1;
                    calibrate <= 1'b0;
                    busy      <= 1'b0;
                    state     <= ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // result held untouched; sdi ignored here
                if (cs_fall) begin
                    int_mode <= ~sck_in;
                    state    <= ST_WAIT;
                    bit_cnt  <= 6'h0;
                    div_cnt  <= 16'h0;
                    sck_out  <= 1'b0;
                end
            end
            ST_WAIT: begin
                if (cs_n) begin
                    state <= ST_SLEEP;
                end else begin
                    state <= ST_XFER;
                end
            end
            ST_XFER: begin
                if (int_mode) begin
                    div_cnt <= div_cnt + 16'h1;
                    if (div_cnt == ISCK_HALF - 16'h1) begin
                        div_cnt <= 16'h0;
                        if (bit_cnt < `XFER_BITS || sck_out) begin
                            sck_out <= ~sck_out;
                        end
                    end
                end
                if (sck_rise && bit_cnt < `XFER_BITS) begin
                    bit_cnt <= bit_cnt + 6'h1;
                    if (bit_cnt < `IN_WORD_BITS) begin
                        shift_in <= {shift_in[6:0], sdi};
                    end
                end
                // a fall ahead of the first rise must not lose the msb
                if (sck_fall && bit_cnt != 6'h0) begin
                    shift_out <= {shift_out[30:0], 1'b0};
                    sdo_bit   <= shift_out[30];
                end
                if (cs_rise && bit_cnt == 6'h0) begin
                    state   <= ST_SLEEP;
                    sck_out <= 1'b0;
                end else if (cs_rise || (bit_cnt == `XFER_BITS && !sck_eff)) begin
                    state      <= ST_CONV;
                    conv_start <= 1'b1;
                    calibrate  <= 1'b1;
                    conv_cnt   <= 32'h0;
                    busy       <= 1'b1;
                    sck_out    <= 1'b0;
                end
            end
            default: begin
                state <= ST_POR;
            end
            endcase
            // channel update once 8 input bits are in
            if (state == ST_XFER && sck_rise && bit_cnt == `IN_WORD_BITS - 1
                && shift_in[6:4] == `CTRL_UPDATE) begin
                channel_addr <= {shift_in[3:0], sdi};
            end
        end
    end

    // ------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------
    result_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_data   (shift_out),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );
    // the fifo copy is a side tap; the serial result never waits on it
    wire unused_ready = fifo_in_ready;
endmodule

// File: verif/adc_cycle_serial_port_monitor.sv
// adc_cycle_serial_port_monitor.sv: port assertions for the converter cycle block
// assumes one clock mclk and synchronous active-high rst
module adc_cycle_serial_port_monitor (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        cs_n,
    input wire logic        sdo_oe,
    input wire logic        sck_oe,
    input wire logic        sck_pullup,
    input wire logic        freq_select_pin,
    input wire logic        ext_clk_detect,
    input wire logic        conv_start,
    input wire logic [4:0]  channel_addr,
    input wire logic        single_ended_select,
    input wire logic        calibrate,
    input wire logic [1:0]  notch_mode,
    input wire logic [31:0] fifo_data,
    input wire logic        fifo_valid,
    input wire logic        fifo_ready,
    input wire logic        busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_sdo_float: assert property (cs_n |-> !sdo_oe) else $error("sdo driven");
    a_sdo_enable: assert property (!cs_n |-> sdo_oe) else $error("sdo off");
    a_pullup_drive: assert property (sck_oe |-> sck_pullup) else $error("no pull-up");
    a_sgl_bit: assert property (single_ended_select == channel_addr[4]) else $error("sgl");
    a_conv_busy: assert property (conv_start |-> ##[0:1] busy) else $error("not busy");
    a_addr_hold: assert property ($changed(channel_addr) |-> !cs_n) else $error("addr");
    a_cal_inside: assert property (calibrate |-> busy) else $error("calibrate idle");
    a_notch_int: assert property ((freq_select_pin && !ext_clk_detect)[*3]
        |-> notch_mode == 2'h1) else $error("notch 50");
    a_notch_ext: assert property (ext_clk_detect[*3] |-> notch_mode == 2'h2)
        else $error("notch ext");
    a_fifo_hold: assert property (fifo_valid && !fifo_ready |=>
        fifo_valid && $stable(fifo_data)) else $error("fifo word lost");
endmodule
bind adc_cycle_serial_port adc_cycle_serial_port_monitor mon (.mclk, .rst, .cs_n, .sdo_oe,
    .sck_oe, .sck_pullup, .freq_select_pin, .ext_clk_detect, .conv_start, .channel_addr,
    .single_ended_select, .calibrate, .notch_mode, .fifo_data, .fifo_valid, .fifo_ready, .busy);

// File: verif/host_model.sv
// host_model.sv: serial master driving select, clock and data input
// assumes external clock mode: clock idles high at select fall
module host_model (
    input  wire logic mclk,
    input  wire logic sdo_line,
    output logic      cs_n,
    output logic      sck,
    output logic      sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        sdi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // n bits, msb first; result bits are taken at each rising clock
    task automatic xfer(input logic [7:0] w, input int n, output logic [31:0] d);
        d = 32'h0;
        cs_n = 1'b0;
        tick(4);
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            sdi = (i < 8) ? w[7 - i] : ~sdi;
            tick(4);
            @(posedge mclk);
            d = {d[30:0], sdo_line};
            #1 sck = 1'b1;
            tick(3);
        end
        sck = 1'b0;
        tick(4);
        cs_n = 1'b1;
        sck = 1'b1;
        tick(1);
    endtask
endmodule

// File: verif/adc_cycle_serial_port_test.sv
// adc_cycle_serial_port_test.sv: self-checking bench with core and host models
// assumes shortened counts: 20 power-on cycles, 64 conversion cycles
`include "adc_cycle_map.vh"
module adc_cycle_serial_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst, cs_n, host_sck, sdi, sck_out, sck_oe, sck_pullup, sdo_out, sdo_oe;
    logic        freq_select_pin, ext_clk_detect, core_overrange, core_underrange, core_done;
    logic        conv_start, single_ended_select, calibrate, fifo_valid, fifo_ready, busy;
    logic [31:0] core_result, fifo_data, exp_word, got, r;
    logic [4:0]  channel_addr, exp_addr;
    logic [1:0]  notch_mode;
    int          num_errors = 0, compares = 0, cyc = 0, conv_count = 0, cdown = 0, flag_mode;
    integer      seed = 32'he65674c7;
    logic [31:0] fifo_q[$];
    wire         sck_line = sck_oe ? sck_out : host_sck;
    wire         sdo_line = sdo_oe ? sdo_out : 1'b0;

    adc_cycle_serial_port #(.POR_CYCLES(20), .CONV_CYCLES(64), .ISCK_HALF(2)) uut (.mclk,
        .rst, .cs_n, .sck_in(sck_line), .sck_out, .sck_oe, .sck_pullup, .sdi, .sdo_out,
        .sdo_oe, .freq_select_pin, .ext_clk_detect, .core_result, .core_overrange,
        .core_underrange, .conv_start, .core_done, .channel_addr, .single_ended_select,
        .calibrate, .notch_mode, .fifo_data, .fifo_valid, .fifo_ready, .busy);
    host_model host (.mclk, .sdo_line, .cs_n, .sck(host_sck), .sdi);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // analog core, fifo drain and timeout
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
        core_done <= #1 1'b0;
        fifo_ready <= #1 $random(seed);
        if (fifo_valid && fifo_ready)
            check("fifo", fifo_data, fifo_q.pop_front());
        if (conv_start) begin
            conv_count <= conv_count + 1;
            cdown <= 10;
            check("channel", {27'h0, channel_addr}, {27'h0, exp_addr});
        end else if (cdown == 1) begin
            r = $random(seed);
            exp_word = flag_mode == 1 ? `OVER_CODE : flag_mode == 2 ? `UNDER_CODE : r;
            fifo_q.push_back(exp_word);
            core_result <= #1 r;
            core_overrange <= #1 flag_mode == 1;
            core_underrange <= #1 flag_mode == 2;
            core_done <= #1 1'b1;
            cdown <= 0;
        end else if (cdown > 0)
            cdown <= cdown - 1;
    end
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic read(input logic [7:0] w, input int n);
        int c;
        for (int k = 0; busy !== 1'b0 && k < 2000; k++)
            tick(1);
        check("sleep", busy, 0);
        if (w[7:5] == 3'h5)
            exp_addr = w[4:0];
        c = conv_count;
        host.xfer(w, n, got);
        check("word", got, exp_word >> (32 - n));
        tick(5);
        check("restart", conv_count, c + 1);
    endtask
    initial begin
        rst = 1'b1;
        freq_select_pin = 1'b1;
        ext_clk_detect = 1'b0;
        core_result = 32'h0;
        core_overrange = 1'b0;
        core_underrange = 1'b0;
        core_done = 1'b0;
        fifo_ready = 1'b0;
        flag_mode = 0;
        exp_addr = 5'h00;
        tick(4);
        rst = 1'b0;
        check("reset addr", channel_addr, 0);
        check("reset sdo", sdo_oe, 0);
        tick(150);
        check("status", sdo_out, 0);
        host.xfer(8'h00, 0, got);
        r = conv_count;
        tick(20);
        check("no restart", conv_count, r);
        $display("test select blip done");
        read({3'h5, 1'b1, 4'($random(seed))}, 32);
        check("sgl", single_ended_select, 1);
        check("pullup", sck_pullup, 0);
        for (int i = 0; i < 3; i++) begin
            read({i == 0 ? 3'h4 : i == 1 ? 3'h0 : 3'h5, 5'($random(seed))}, 32);
        end
        $display("test channel words done");
        read(8'ha3, 10);
        read(8'h80, 32);
        $display("test abort done");
        for (int m = 1; m <= 3; m++) begin
            flag_mode = m % 3;
            read(8'h00, 32);
            read(8'h00, 32);
        end
        $display("test range codes done");
        for (int i = 0; i < 4; i++) begin
            freq_select_pin = i[0];
            ext_clk_detect = i[1];
            tick(4);
            check("notch", notch_mode, i[1] ? 2 : i[0]);
        end
        $display("test notch done");
        conclude();
    end
endmodule
